// ==== bench/dcsr_mpu_model.sv ====
// local processor model: byte register reads and writes
`default_nettype none
module dcsr_mpu_model (
   input wire logic clock,
   output logic [7:0] addr,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {addr, wr_en, rd_en, wdata} = 18'h00000;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      // released data does not keep the old value
      wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      // registered answer stands from the sampling edge until the next read
      @(posedge clock);
      d = rdata;
   endtask
endmodule // dcsr_mpu_model
`default_nettype wire

// ==== bench/dcsr_regs_bench.sv ====
// self-checking bench for the disk control and status register group
`default_nettype none
module dcsr_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, nrst = 1'b0, rck = 1'b0, rck_on = 1'b1, eq = 1'b0, grp = 1'b0;
   logic swp = 1'b0, dbr = 1'b0;
   logic wr_en, rd_en, seq_sync_found, split_fifo_pop, split_fifo_from_buffer_en;
   logic external_sync_en, seq_stop_req, servo_overrun_flag, disk_event_irq;
   logic [7:0] addr, wdata, rdata, got, polv = 8'h00, ien = 8'h00;
   logic [15:0] rv = 16'h0008;
   logic [17:0] pulse = 18'h00000;
   int mismatches = 0, tests_run = 0;
   logic [7:0] ra [4] = '{8'h63, 8'h66, 8'h67, 8'h50};
   // address, bit number and clearing address of the flag set by each of pulse bits 0 to 15
   logic [23:0] tbl [16] = '{24'h640764, 24'h640664, 24'h640164, 24'h650165,
      24'h660666, 24'h660566, 24'h660566, 24'h660366, 24'h660266, 24'h660166,
      24'h650077, 24'h660066, 24'h650465, 24'h650565, 24'h650765, 24'h650665};
   wire logic sync_found_in = 1'b0, byte_address_swap = swp, disk_block_reset = dbr;
   wire logic external_sync_found_in = rv[11], internal_sync_found = rv[12];
   // pins idle at the inactive level of the programmed polarity
   wire logic sector_in = pulse[12] ^ ~polv[6], index_in = pulse[13] ^ ~polv[5];
   wire logic servo_end_in = (pulse[14] | pulse[15]) ^ ~polv[4], read_ref_clock = rck;
   wire logic seed_overflow_ev = pulse[0], split_parity_ev = pulse[1];
   wire logic sector_valid_wait_timeout = pulse[2], servo_compare_wait_timeout = pulse[3];
   wire logic seq_wait_timeout = pulse[4], uncorrectable_ev = pulse[5];
   wire logic corr_threshold_ev = pulse[6], corrected_ev = pulse[7], sector_wrap_ev = pulse[8];
   wire logic sector_good_ev = pulse[9], index_counter_dec_zero = pulse[10];
   wire logic seq_running = ~pulse[11], clear_two_index_timeout_op = pulse[16];
   wire logic wait_is_defect_flag = pulse[17], disk_event_group_irq_en = grp;
   wire logic [5:0] disk_fifo_level = rv[9:4];
   wire logic [9:0] requested_sector_num = rv[9:0];
   wire logic [9:0] stop_sector_num = rv[10] ? rv[9:0] : rv[15:6];
   wire logic [7:0] servo_end_counter = rv[7:0], servo_compare_value = eq ? rv[7:0] : ~rv[7:0];
   wire logic gp_pin_output_en = rv[0], gp_out_pin = rv[1], gp_in_pin = rv[2];
   wire logic seq_output_fn = rv[3], stop_on_seed_overrun = rv[13];
   wire logic stop_on_split_parity = rv[14], stop_on_two_index_timeout = rv[15];
   wire logic stop_on_uncorrectable = rv[12];
   dcsr_mpu_model i_mpu (.clock, .addr, .wr_en, .rd_en, .wdata, .rdata);
   dcsr_regs i_dut (.clock, .nrst, .addr, .wr_en, .rd_en, .wdata, .rdata, .sync_found_in,
      .external_sync_found_in, .sector_in, .index_in, .servo_end_in, .read_ref_clock,
      .internal_sync_found, .seed_overflow_ev, .split_parity_ev, .sector_valid_wait_timeout,
      .servo_compare_wait_timeout, .seq_wait_timeout, .wait_is_defect_flag,
      .clear_two_index_timeout_op, .uncorrectable_ev, .corr_threshold_ev, .corrected_ev,
      .sector_wrap_ev, .sector_good_ev, .seq_running, .disk_fifo_level, .requested_sector_num,
      .stop_sector_num, .servo_end_counter, .servo_compare_value, .gp_pin_output_en,
      .gp_out_pin, .gp_in_pin, .seq_output_fn, .index_counter_dec_zero, .byte_address_swap,
      .disk_block_reset, .stop_on_seed_overrun, .stop_on_split_parity,
      .stop_on_two_index_timeout, .stop_on_uncorrectable, .disk_event_group_irq_en,
      .seq_sync_found, .split_fifo_pop, .split_fifo_from_buffer_en, .external_sync_en,
      .seq_stop_req, .servo_overrun_flag, .disk_event_irq);
   always #25 clock = ~clock;
   always @(posedge clock) if (rck_on) rck <= ~rck;
   function automatic logic [15:0] lfsr(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [7:0] exp_a(logic [15:0] v);
      return {5'h00, v[9:4] < dcsr_pkg::FIFO_READY_LEVEL, 1'b0, v[10] || v[9:0] == v[15:6]};
   endfunction
   function automatic logic [7:0] exp_b(logic [15:0] v);
      return {4'h0, v[0] ? v[1] : v[3], ~v[0] & v[2], 2'h0};
   endfunction
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // pins pass two sync stages, so every pulse gets a few settling cycles
   task automatic pul(input logic [17:0] p);
      @(posedge clock);
      pulse <= p;
      @(posedge clock);
      pulse <= 18'h00000;
      repeat (4) @(posedge clock);
   endtask
   task automatic flag(input int k);
      logic [7:0] a, m, c;
      {a, m, c} = tbl[k];
      m = 8'h01 << m;
      // swapped byte order moves the counter's upper byte to the lower address
      if (k == 10 && swp) c = 8'h76;
      eq <= (k == 15);
      i_mpu.wr(c, m);
      pul((18'h00001 << k) | 18'h10000);
      i_mpu.rd(a, got);
      check(got & m, m);
      if (a == 8'h66) check({7'h00, disk_event_irq}, {7'h00, grp & |(ien & m)});
      i_mpu.wr(c, m);
      i_mpu.rd(a, got);
      check(got & m, 8'h00);
      check({7'h00, disk_event_irq}, 8'h00);
   endtask
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      i_mpu.wr(8'h50, 8'hff);
      foreach (ra[j]) begin
         i_mpu.rd(ra[j], got);
         check(got, 8'h00);
      end
      for (int i = 0; i < 20; i++) begin
         @(posedge clock);
         rv <= lfsr(rv);
         i_mpu.rd(8'h64, got);
         check(got & 8'he7, exp_a(rv));
         i_mpu.rd(8'h65, got);
         check(got & 8'h0c, exp_b(rv));
         i_mpu.wr(8'h63, rv[7:0]);
         i_mpu.rd(8'h63, got);
         check(got, rv[7:0] & dcsr_pkg::POLARITY_RW_MASK);
         check({6'h00, split_fifo_from_buffer_en, external_sync_en}, {6'h00, rv[1:0]});
         i_mpu.rd(dcsr_pkg::OFS_SPLIT_FIFO_1, got);
      end
      for (int p = 0; p < 2; p++) begin
         polv <= p ? rv[15:8] : 8'h00;
         ien <= p ? 8'h0f : 8'hff;
         grp <= p[0];
         swp <= p[0];
         @(posedge clock);
         i_mpu.wr(8'h63, polv);
         i_mpu.wr(8'h67, ien);
         i_mpu.rd(8'h67, got);
         check(got, ien & dcsr_pkg::EVENT_MASK);
         repeat (6) @(posedge clock);
         for (int k = 0; k < 16; k++) flag(k);
      end
      pul(18'h20010);
      i_mpu.rd(8'h66, got);
      check(got & 8'h40, 8'h00);
      i_mpu.wr(8'h66, 8'h80);
      pul(18'h10000);
      pul(18'h02000);
      i_mpu.rd(8'h66, got);
      check(got & 8'h80, 8'h00);
      pul(18'h02000);
      i_mpu.rd(8'h66, got);
      check(got & 8'h80, 8'h80);
      check({7'h00, seq_stop_req}, {7'h00, rv[15]});
      i_mpu.wr(8'h66, 8'h80);
      i_mpu.rd(8'h66, got);
      check(got & 8'h80, 8'h00);
      // sector held asserted: the leading-edge detector has set the flag by now
      pulse <= 18'h01000;
      repeat (4) @(posedge clock);
      i_mpu.rd(8'h65, got);
      check(got & 8'h10, 8'h10);
      pulse <= 18'h00000;
      rck_on <= 1'b0;
      repeat (24) @(posedge clock);
      i_mpu.rd(8'h64, got);
      check(got & 8'h20, 8'h20);
      rck_on <= 1'b1;
      repeat (6) @(posedge clock);
      i_mpu.wr(8'h64, 8'h20);
      i_mpu.rd(8'h64, got);
      check(got & 8'h20, 8'h00);
      rck_on <= 1'b0;
      repeat (24) @(posedge clock);
      rck_on <= 1'b1;
      repeat (6) @(posedge clock);
      dbr <= 1'b1;
      @(posedge clock);
      dbr <= 1'b0;
      i_mpu.rd(8'h64, got);
      check(got & 8'h20, 8'h00);
      pul(18'h00001);
      check({7'h00, seq_stop_req}, {7'h00, rv[13]});
      pul(18'h00002);
      check({7'h00, seq_stop_req}, {7'h00, rv[13] | rv[14]});
      report_and_stop();
   end
endmodule // dcsr_regs_bench
`default_nettype wire

// ==== bench/dcsr_regs_checker.sv ====
// checker: port-level assertions for the disk register group
`default_nettype none
module dcsr_regs_checker (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic internal_sync_found,
   input wire logic seq_wait_timeout,
   input wire logic wait_is_defect_flag,
   input wire logic disk_event_group_irq_en,
   input wire logic seq_sync_found,
   input wire logic split_fifo_pop,
   input wire logic split_fifo_from_buffer_en,
   input wire logic external_sync_en,
   input wire logic servo_overrun_flag,
   input wire logic disk_event_irq
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   logic pop_en_r;
   wire logic ctl_wr = wr_en && addr == dcsr_pkg::OFS_POLARITY;
   // pop enable is not a port, so it is shadowed from the writes
   always_ff @(posedge clock) begin
      if (!nrst) pop_en_r <= 1'b0;
      else if (ctl_wr) pop_en_r <= wdata[dcsr_pkg::CTL_POP];
   end
   a_pop_on_read: assert property (split_fifo_pop ==
      (rd_en && pop_en_r && addr == dcsr_pkg::OFS_SPLIT_FIFO_1)) else $error("pop wrong");
   a_buf_src_set: assert property (ctl_wr |=>
      split_fifo_from_buffer_en == $past(wdata[1])) else $error("source select wrong");
   a_ext_sync_set: assert property (ctl_wr |=>
      external_sync_en == $past(wdata[0])) else $error("sync select wrong");
   a_ctl_hold: assert property (!ctl_wr |=> $stable(external_sync_en) &&
      $stable(split_fifo_from_buffer_en)) else $error("control moved without write");
   a_int_sync: assert property (!external_sync_en |->
      seq_sync_found == internal_sync_found) else $error("internal sync not used");
   a_event_rsv: assert property (rd_en && addr == dcsr_pkg::OFS_EVENT |=>
      !rdata[4]) else $error("event reserved bit set");
   a_ctl_rsv: assert property (rd_en && addr == dcsr_pkg::OFS_POLARITY |=>
      !rdata[3]) else $error("control reserved bit set");
   a_defect_to: assert property (seq_wait_timeout && wait_is_defect_flag |=>
      servo_overrun_flag) else $error("overrun flag missing");
   a_irq_gate: assert property (!disk_event_group_irq_en |-> !disk_event_irq)
      else $error("irq without group enable");
   c_pop: cover property (split_fifo_pop);
   c_irq: cover property (disk_event_irq);
   c_ovr: cover property (servo_overrun_flag);
endmodule // dcsr_regs_checker
bind dcsr_regs dcsr_regs_checker i_chk (.clock, .nrst, .addr, .wr_en, .rd_en, .wdata, .rdata,
   .internal_sync_found, .seq_wait_timeout, .wait_is_defect_flag, .disk_event_group_irq_en,
   .seq_sync_found, .split_fifo_pop, .split_fifo_from_buffer_en, .external_sync_en,
   .servo_overrun_flag, .disk_event_irq);
`default_nettype wire

// ==== verilog/dcsr_edge_det.sv ====
// module: polarity selection and asserting-edge detection on four disk pins
`default_nettype none
module dcsr_edge_det (
   input wire logic clock,
   input wire logic nrst,
   dcsr_edge_if.det e
);
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] last;
   } dcsr_ed_t;
   dcsr_ed_t st_r;
   dcsr_ed_t st_nxt;
   logic [3:0] active;
   always_comb begin
      st_nxt = st_r;
      // two stages so a pin change near the clock edge cannot reach the flags
      st_nxt.s1 = e.pins;
      st_nxt.s2 = st_r.s1;
      active = st_r.s2 ^ ~e.pol_hi;
      st_nxt.last = active;
   end
   // polarity flip also moves the detected edge; rising of the corrected level
   assign e.rise = active & ~st_r.last;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         // stages start at the idle level of an active-low pin: no false edge after reset
         st_r <= '{s1: 4'hf, s2: 4'hf, last: 4'h0};
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // dcsr_edge_det
`default_nettype wire

// ==== verilog/dcsr_edge_if.sv ====
// interface: polarity-corrected pin edges passed from the edge block to the register top
`default_nettype none
interface dcsr_edge_if;
   logic [3:0] pol_hi;
   logic [3:0] pins;
   logic [3:0] rise;
   modport det (input pol_hi, input pins, output rise);
   modport top (output pol_hi, output pins, input rise);
endinterface
`default_nettype wire

// ==== verilog/dcsr_pkg.sv ====
// package: register offsets, bit positions and timing counts for the disk status registers
`default_nettype none
package dcsr_pkg;
   localparam logic [7:0] OFS_POLARITY = 8'h63;
   localparam logic [7:0] OFS_STATUS_A = 8'h64;
   localparam logic [7:0] OFS_STATUS_B = 8'h65;
   localparam logic [7:0] OFS_EVENT = 8'h66;
   localparam logic [7:0] OFS_EVENT_EN = 8'h67;
   localparam logic [7:0] OFS_SPLIT_FIFO_1 = 8'h79;
   localparam logic [7:0] OFS_INDEX_CTR_0 = 8'h76;
   localparam logic [7:0] OFS_INDEX_CTR_1 = 8'h77;
   // polarity/control register bits
   localparam int POL_SYNC = 7;
   localparam int POL_SECTOR = 6;
   localparam int POL_INDEX = 5;
   localparam int POL_SERVO = 4;
   localparam int CTL_POP = 2;
   localparam int CTL_BUFSRC = 1;
   localparam int CTL_EXTSYNC = 0;
   localparam logic [7:0] POLARITY_RW_MASK = 8'hf7;
   localparam logic [7:0] POLARITY_RESET = 8'h00;
   // status a bits
   localparam int SA_SEED_OVR = 7;
   localparam int SA_SPLIT_PAR = 6;
   localparam int SA_RCLK_MISS = 5;
   localparam int SA_BUF_NRDY = 2;
   localparam int SA_SEC_TO = 1;
   localparam int SA_STOP_SEC = 0;
   // status b bits
   localparam int SB_SERVO_END = 7;
   localparam int SB_SERVO_CMP = 6;
   localparam int SB_INDEX = 5;
   localparam int SB_SECTOR = 4;
   localparam int SB_SEQ_OUT = 3;
   localparam int SB_SEQ_IN = 2;
   localparam int SB_SERVO_TO = 1;
   localparam int SB_IDX_ZERO = 0;
   // event bits
   localparam int EV_TWO_IDX = 7;
   localparam int EV_WAIT_TO = 6;
   localparam int EV_UNCORRECTABLE_ERROR = 5;
   localparam int EV_CORR = 3;
   localparam int EV_WRAP = 2;
   localparam int EV_SEC_OK = 1;
   localparam int EV_STOPPED = 0;
   localparam logic [7:0] EVENT_MASK = 8'hef;
   // timing, levels and widths
   localparam int CLOCK_PERIOD_NS = 50;
   localparam int RCLK_MISS_CYCLES = 16;
   localparam int FIFO_READY_LEVEL = 8;
   localparam int SECTOR_BITS = 10;
endpackage
`default_nettype wire

// ==== verilog/dcsr_rclk_mon.sv ====
// module: missing read reference clock watchdog
`default_nettype none
module dcsr_rclk_mon #(
   parameter int LIMIT = dcsr_pkg::RCLK_MISS_CYCLES
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic read_ref_clock,
   output logic missing
);
   initial begin
      if (LIMIT < 2 || LIMIT > 255) $error("dcsr_rclk_mon: bad LIMIT");
   end
   typedef struct packed {
      logic s1;
      logic s2;
      logic last;
      logic [7:0] cnt;
   } dcsr_rm_t;
   dcsr_rm_t st_r;
   dcsr_rm_t st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = read_ref_clock;
      st_nxt.s2 = st_r.s1;
      st_nxt.last = st_r.s2;
      if (st_r.s2 && !st_r.last) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt != 8'(LIMIT)) begin
         st_nxt.cnt = st_r.cnt + 8'h01;
      end
   end
   // a clock above half the buffer rate aliases here; watchdog only
   assign missing = (st_r.cnt == 8'(LIMIT));
   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // dcsr_rclk_mon
`default_nettype wire

// ==== verilog/dcsr_regs.sv ====
// module: disk control, status and event register group
`default_nettype none
module dcsr_regs #(
   parameter int FIFO_LEVEL_W = 6,
   parameter int READY_LEVEL = dcsr_pkg::FIFO_READY_LEVEL
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic sync_found_in,
   input wire logic external_sync_found_in,
   input wire logic sector_in,
   input wire logic index_in,
   input wire logic servo_end_in,
   input wire logic read_ref_clock,
   input wire logic internal_sync_found,
   input wire logic seed_overflow_ev,
   input wire logic split_parity_ev,
   input wire logic sector_valid_wait_timeout,
   input wire logic servo_compare_wait_timeout,
   input wire logic seq_wait_timeout,
   input wire logic wait_is_defect_flag,
   input wire logic clear_two_index_timeout_op,
   input wire logic uncorrectable_ev,
   input wire logic corr_threshold_ev,
   input wire logic corrected_ev,
   input wire logic sector_wrap_ev,
   input wire logic sector_good_ev,
   input wire logic seq_running,
   input wire logic [FIFO_LEVEL_W-1:0] disk_fifo_level,
   input wire logic [dcsr_pkg::SECTOR_BITS-1:0] requested_sector_num,
   input wire logic [dcsr_pkg::SECTOR_BITS-1:0] stop_sector_num,
   input wire logic [7:0] servo_end_counter,
   input wire logic [7:0] servo_compare_value,
   input wire logic gp_pin_output_en,
   input wire logic gp_out_pin,
   input wire logic gp_in_pin,
   input wire logic seq_output_fn,
   input wire logic index_counter_dec_zero,
   input wire logic byte_address_swap,
   input wire logic disk_block_reset,
   input wire logic stop_on_seed_overrun,
   input wire logic stop_on_split_parity,
   input wire logic stop_on_two_index_timeout,
   input wire logic stop_on_uncorrectable,
   input wire logic disk_event_group_irq_en,
   output logic seq_sync_found,
   output logic split_fifo_pop,
   output logic split_fifo_from_buffer_en,
   output logic external_sync_en,
   output logic seq_stop_req,
   output logic servo_overrun_flag,
   output logic disk_event_irq
);
   initial begin
      if (READY_LEVEL < 1 || READY_LEVEL >= (1 << FIFO_LEVEL_W))
         $error("dcsr_regs: READY_LEVEL does not fit FIFO_LEVEL_W");
   end
   typedef struct packed {
      logic [7:0] pol;
      logic seed_ovr;
      logic split_par;
      logic rclk_miss;
      logic sec_to;
      logic servo_end_seen;
      logic servo_compare_seen;
      logic index_seen;
      logic sector_seen;
      logic servo_to;
      logic idx_zero;
      logic [7:0] event_st;
      logic [7:0] event_en;
      logic [1:0] idx_cnt;
      logic run_last;
      logic srv_ovr;
      logic [7:0] rdata;
   } dcsr_st_t;
   dcsr_st_t st_r;
   dcsr_st_t st_nxt;
   dcsr_edge_if eif ();
   logic rclk_missing;
   logic [7:0] sa_val;
   logic [7:0] sb_val;
   logic [7:0] ev_set;

   // one-flag sticky update: hardware set beats software clear
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set | (cur & ~clr);
   endfunction

   assign eif.pol_hi = {st_r.pol[dcsr_pkg::POL_SECTOR], st_r.pol[dcsr_pkg::POL_INDEX],
                        st_r.pol[dcsr_pkg::POL_SERVO], st_r.pol[dcsr_pkg::POL_SYNC]};
   assign eif.pins = {sector_in, index_in, servo_end_in, external_sync_found_in};

   dcsr_edge_det u_edge (
      .clock(clock),
      .nrst(nrst),
      .e(eif.det)
   );

   dcsr_rclk_mon u_rclk (
      .clock(clock),
      .nrst(nrst),
      .read_ref_clock(read_ref_clock),
      .missing(rclk_missing)
   );

   logic wr_pol;
   logic wr_sa;
   logic wr_sb;
   logic wr_ev;
   logic wr_en_reg;
   logic wr_idx_hi;
   logic servo_edge;
   logic idx_edge;
   logic sec_edge;
   logic two_idx_hit;

   always_comb begin
      wr_pol = wr_en && addr == dcsr_pkg::OFS_POLARITY;
      wr_sa = wr_en && addr == dcsr_pkg::OFS_STATUS_A;
      wr_sb = wr_en && addr == dcsr_pkg::OFS_STATUS_B;
      wr_ev = wr_en && addr == dcsr_pkg::OFS_EVENT;
      wr_en_reg = wr_en && addr == dcsr_pkg::OFS_EVENT_EN;
      // upper counter byte moves to the low address when bytes are swapped
      wr_idx_hi = wr_en && (addr == (byte_address_swap ? dcsr_pkg::OFS_INDEX_CTR_0
                                                       : dcsr_pkg::OFS_INDEX_CTR_1));
      servo_edge = eif.rise[1];
      idx_edge = eif.rise[2];
      sec_edge = eif.rise[3];
      two_idx_hit = idx_edge && st_r.idx_cnt == 2'd1 && !clear_two_index_timeout_op;
      ev_set = '0;
      ev_set[dcsr_pkg::EV_TWO_IDX] = two_idx_hit;
      ev_set[dcsr_pkg::EV_WAIT_TO] = seq_wait_timeout && !wait_is_defect_flag;
      ev_set[dcsr_pkg::EV_UNCORRECTABLE_ERROR] = uncorrectable_ev || corr_threshold_ev;
      ev_set[dcsr_pkg::EV_CORR] = corrected_ev;
      ev_set[dcsr_pkg::EV_WRAP] = sector_wrap_ev;
      ev_set[dcsr_pkg::EV_SEC_OK] = sector_good_ev;
      ev_set[dcsr_pkg::EV_STOPPED] = st_r.run_last && !seq_running;
   end

   always_comb begin
      sa_val = '0;
      sa_val[dcsr_pkg::SA_SEED_OVR] = st_r.seed_ovr;
      sa_val[dcsr_pkg::SA_SPLIT_PAR] = st_r.split_par;
      sa_val[dcsr_pkg::SA_RCLK_MISS] = st_r.rclk_miss;
      sa_val[dcsr_pkg::SA_BUF_NRDY] =
         disk_fifo_level < FIFO_LEVEL_W'(READY_LEVEL);
      sa_val[dcsr_pkg::SA_SEC_TO] = st_r.sec_to;
      sa_val[dcsr_pkg::SA_STOP_SEC] = requested_sector_num == stop_sector_num;
      sb_val = '0;
      sb_val[dcsr_pkg::SB_SERVO_END] = st_r.servo_end_seen;
      sb_val[dcsr_pkg::SB_SERVO_CMP] = st_r.servo_compare_seen;
      sb_val[dcsr_pkg::SB_INDEX] = st_r.index_seen;
      sb_val[dcsr_pkg::SB_SECTOR] = st_r.sector_seen;
      sb_val[dcsr_pkg::SB_SEQ_OUT] = gp_pin_output_en ? gp_out_pin : seq_output_fn;
      sb_val[dcsr_pkg::SB_SEQ_IN] = gp_pin_output_en ? 1'b0 : gp_in_pin;
      sb_val[dcsr_pkg::SB_SERVO_TO] = st_r.servo_to;
      sb_val[dcsr_pkg::SB_IDX_ZERO] = st_r.idx_zero;
   end

   always_comb begin
      st_nxt = st_r;
      if (wr_pol) begin
         st_nxt.pol = wdata & dcsr_pkg::POLARITY_RW_MASK;
      end
      st_nxt.seed_ovr = sticky(st_r.seed_ovr, seed_overflow_ev,
                               wr_sa && wdata[dcsr_pkg::SA_SEED_OVR]);
      st_nxt.split_par = sticky(st_r.split_par, split_parity_ev,
                                wr_sa && wdata[dcsr_pkg::SA_SPLIT_PAR]);
      st_nxt.rclk_miss = sticky(st_r.rclk_miss, rclk_missing,
                                disk_block_reset || (wr_sa && wdata[dcsr_pkg::SA_RCLK_MISS]));
      st_nxt.sec_to = sticky(st_r.sec_to, sector_valid_wait_timeout,
                             wr_sa && wdata[dcsr_pkg::SA_SEC_TO]);
      st_nxt.servo_to = sticky(st_r.servo_to, servo_compare_wait_timeout,
                               wr_sb && wdata[dcsr_pkg::SB_SERVO_TO]);
      st_nxt.servo_end_seen = sticky(st_r.servo_end_seen, servo_edge,
                                     wr_sb && wdata[dcsr_pkg::SB_SERVO_END]);
      st_nxt.servo_compare_seen = sticky(st_r.servo_compare_seen,
                                         servo_edge && servo_end_counter == servo_compare_value,
                                         wr_sb && wdata[dcsr_pkg::SB_SERVO_CMP]);
      st_nxt.index_seen = sticky(st_r.index_seen, idx_edge,
                                 wr_sb && wdata[dcsr_pkg::SB_INDEX]);
      st_nxt.sector_seen = sticky(st_r.sector_seen, sec_edge,
                                  wr_sb && wdata[dcsr_pkg::SB_SECTOR]);
      st_nxt.idx_zero = sticky(st_r.idx_zero, index_counter_dec_zero, wr_idx_hi);
      // two-index counter restarts on the sequencer decode
      if (clear_two_index_timeout_op) begin
         st_nxt.idx_cnt = 2'd0;
      end else if (idx_edge && st_r.idx_cnt != 2'd2) begin
         st_nxt.idx_cnt = st_r.idx_cnt + 2'd1;
      end
      st_nxt.event_st = (ev_set | (st_r.event_st & ~(wr_ev ? wdata : 8'h00)))
                        & dcsr_pkg::EVENT_MASK;
      if (wr_en_reg) begin
         st_nxt.event_en = wdata & dcsr_pkg::EVENT_MASK;
      end
      st_nxt.run_last = seq_running;
      st_nxt.srv_ovr = seq_wait_timeout && wait_is_defect_flag;
      unique case (addr)
         dcsr_pkg::OFS_POLARITY: st_nxt.rdata = st_r.pol;
         dcsr_pkg::OFS_STATUS_A: st_nxt.rdata = sa_val;
         dcsr_pkg::OFS_STATUS_B: st_nxt.rdata = sb_val;
         dcsr_pkg::OFS_EVENT: st_nxt.rdata = st_r.event_st;
         dcsr_pkg::OFS_EVENT_EN: st_nxt.rdata = st_r.event_en;
         default: st_nxt.rdata = 8'h00;
      endcase
      if (!rd_en) begin
         st_nxt.rdata = st_r.rdata;
      end
   end

   assign rdata = st_r.rdata;
   assign split_fifo_pop = rd_en && addr == dcsr_pkg::OFS_SPLIT_FIFO_1
                           && st_r.pol[dcsr_pkg::CTL_POP];
   assign split_fifo_from_buffer_en = st_r.pol[dcsr_pkg::CTL_BUFSRC];
   assign external_sync_en = st_r.pol[dcsr_pkg::CTL_EXTSYNC];
   // external mark uses its programmed polarity; offset alignment lives in the sequencer
   assign seq_sync_found = external_sync_en ? eif.rise[0] : internal_sync_found;
   assign seq_stop_req = (st_r.seed_ovr && stop_on_seed_overrun)
                         || (st_r.split_par && stop_on_split_parity)
                         || (st_r.event_st[dcsr_pkg::EV_TWO_IDX] && stop_on_two_index_timeout)
                         || (st_r.event_st[dcsr_pkg::EV_UNCORRECTABLE_ERROR] && stop_on_uncorrectable);
   assign servo_overrun_flag = st_r.srv_ovr;
   assign disk_event_irq = disk_event_group_irq_en
                           && |(st_r.event_st & st_r.event_en);

   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // dcsr_regs
`default_nettype wire
